//--- bench/whb_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// External address latch and peripheral memory
// ****************************************************************
module whb_periph_model (
  // Clock
  input  wire logic        ref_clk,
  // Configuration seen by the board
  input  wire logic [1:0]  cs_cfg,
  // Port lines
  input  wire logic [31:0] line_out,
  input  wire logic [31:0] line_oe,
  input  wire logic [1:0]  byte_lane_n,
  input  wire logic        byte_lane_oe,
  output logic      [15:0] line_in
);
  bit   [15:0] mem [int];
  logic [25:0] lat_q;
  logic        sel_q;
  logic        sel;
  logic [15:0] last_q;
  logic        rd;
  logic        wr;

  // A strobe counts only while the port drives it; a released port is idle
  assign rd = line_oe[28] && !line_out[28];
  assign wr = line_oe[29] && !line_out[29];

  assign sel = (cs_cfg == 2'h2) ? !(line_out[30] && line_out[27]) : !line_out[30];

  always @(posedge ref_clk) begin
    sel_q <= sel;
    // Without a latch pulse the only address marker is the select edge
    if ((cs_cfg[0] == cs_cfg[1]) ? line_out[30] : (sel && !sel_q)) begin
      lat_q <= line_out[25:0];
    end
    if (wr) begin
      if (!mem.exists(lat_q)) mem[lat_q] = 16'h0000;
      for (int i = 0; i < 2; i++) begin
        if (!byte_lane_oe || !byte_lane_n[i]) mem[lat_q][8*i +: 8] = line_out[8*i +: 8];
      end
    end
    if (rd) last_q <= mem[lat_q];
  end

  // A released bus shows the inverse of the last value, never a stale copy
  always @* line_in = rd ? mem[lat_q] : ~last_q;
endmodule // whb_periph_model
`default_nettype wire

//--- bench/whb_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module whb_port_tb;
  logic        ref_clk;
  logic        rst_n;
  logic [3:0]  port_mode;
  logic [1:0]  wide_mode;
  logic [1:0]  byte_lane_select;
  logic [1:0]  chip_select_config;
  logic        cfg_ok;
  logic        req_valid;
  logic        req_ready;
  logic        req_write;
  logic [27:0] req_addr;
  logic [15:0] req_wdata;
  logic [1:0]  req_be;
  logic        rsp_valid;
  logic [15:0] rsp_rdata;
  logic [15:0] line_in;
  logic [31:0] line_out;
  logic [31:0] line_oe;
  logic [1:0]  byte_lane_n;
  logic        byte_lane_oe;
  int          fails;
  int          compares;
  bit   [15:0] mem_m [int];

  whb_port i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .port_mode(port_mode),
    .wide_mode(wide_mode), .byte_lane_select(byte_lane_select),
    .chip_select_config(chip_select_config), .cfg_ok(cfg_ok), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_be(req_be), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
    .byte_lane_n(byte_lane_n), .byte_lane_oe(byte_lane_oe));

  whb_periph_model i_periph (.ref_clk(ref_clk), .cs_cfg(chip_select_config),
    .line_out(line_out), .line_oe(line_oe), .byte_lane_n(byte_lane_n),
    .byte_lane_oe(byte_lane_oe), .line_in(line_in));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************************************
  // One access, checked phase by phase against the expected pin image
  // ****************************************************************
  task automatic access(input logic w, input logic [27:0] a, input logic [15:0] d,
                        input logic [1:0] be);
    logic [1:0]  cf;
    logic        ale;
    logic [2:0]  sel;
    logic [15:0] exp;
    int          n;
    cf  = chip_select_config;
    ale = (cf == 2'h0) || (cf == 2'h3);
    case (cf)
      2'h0: sel = {1'b1, a[27:26]};
      2'h1: sel = {1'b0, a[27:26]};
      2'h2: sel = {a[27], !a[27], a[26]};
      default: sel = {1'b1, !a[26], a[26]};
    endcase
    exp = mem_m.exists(a[25:0]) ? mem_m[a[25:0]] : 16'h0000;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_be = be;
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chk("req_ready", 32'h1, 32'(req_ready));
    @(posedge ref_clk);
    for (int k = 1; k <= 9; k++) begin
      @(negedge ref_clk);
      if (k == 1) begin
        req_valid = 1'b0;
        chk("ad_addr", {a[15:0], 16'hFFFF}, {line_out[15:0], line_oe[15:0]});
        chk("upper_addr", 32'(a[25:16]), 32'(line_out[25:16]));
        chk("line_oe_up", 32'h7FFF, 32'(line_oe[31:16]));
        chk("sel_lines", {sel, 2'h3}, {line_out[30], line_out[27:26], line_out[29:28]});
      end
      if (k == 3) chk("ale_end", {sel[2] & !ale, a[15:0]}, {line_out[30], line_out[15:0]});
      if (k == 5) begin
        chk("sel_held", sel & {!ale, 2'h3}, {line_out[30], line_out[27:26]});
        chk("strobes", {!w, w}, line_out[29:28]);
        chk("data_oe", {16{w}}, line_oe[15:0]);
        if (w) chk("wdata", d, line_out[15:0]);
        chk("lanes", {!byte_lane_select[0], byte_lane_select[0] ? 2'h3 : ~be},
            {byte_lane_oe, byte_lane_n | {2{!byte_lane_oe}}});
      end
      if (k == 8) chk("recovery", 3'h6, {line_out[29:28], rsp_valid});
    end
    chk("idle", {1'b1, !ale}, {rsp_valid, line_out[30]});
    if (cf[1]) chk("idle_cs1", 1'b1, line_out[27]);
    if (cf == 2'h3) chk("idle_cs0", 1'b1, line_out[26]);
    if (!w) chk("rdata", exp, rsp_rdata);
    if (w && !mem_m.exists(a[25:0])) mem_m[a[25:0]] = 16'h0000;
    for (int i = 0; i < 2; i++) begin
      if (w && be[i]) mem_m[a[25:0]][8*i +: 8] = d[8*i +: 8];
    end
  endtask

  initial begin
    logic [27:0] a;
    logic [15:0] d;
    logic [1:0]  be;
    void'($urandom(32'h18c49b17));
    rst_n = 1'b0;
    port_mode = 4'h3;
    wide_mode = 2'h0;
    byte_lane_select = 2'h1;
    chip_select_config = 2'h0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 28'h0;
    req_wdata = 16'h0;
    req_be = 2'h3;
    repeat (5) @(negedge ref_clk);
    chk("reset_oe", 32'h0, line_oe);
    chk("reset_lanes", 3'h3, {byte_lane_oe, byte_lane_n});
    rst_n = 1'b1;
    // Wrong mode fields must keep a pending request out entirely
    for (int m = 2; m >= 0; m--) begin
      port_mode = (m == 1) ? 4'(3 + $urandom_range(1, 15)) : 4'h3;
      wide_mode = (m == 2) ? 2'($urandom_range(1, 3)) : 2'h0;
      req_valid = (m != 0);
      repeat (12) begin
        @(negedge ref_clk);
        chk("cfg_gate", {m == 0, m == 0, 1'b0}, {cfg_ok, req_ready, rsp_valid});
      end
    end
    // Every select layout with and without lanes, write then read back to back
    for (int c = 0; c < 8; c++) begin
      chip_select_config = 2'(c);
      byte_lane_select = {1'b0, c[2]};
      // Let the idle pin image settle under the new layout before the next access
      repeat (2) @(negedge ref_clk);
      chk("idle_layout", 32'(c[0] != c[1]), 32'(line_out[30]));
      for (int i = 0; i < 3; i++) begin
        a = 28'($urandom);
        d = 16'($urandom);
        be = c[2] ? 2'h3 : 2'($urandom_range(1, 3));
        access(1'b1, a, d, be);
        access(1'b0, a, 16'h0, 2'h3);
      end
    end
    summarize();
  end

  // The tests need about 490 cycles; this leaves a wide margin
  initial begin
    #50us;
    fails++;
    summarize();
  end
endmodule // whb_port_tb
`default_nettype wire

//--- core/whb_pkg.sv
// Overview of operation
// - Port runs the wide host-bus protocol only when port mode equals 0x3.
// - Wide-bus mode 0x0 selects multiplexed address and data operation.
// - Byte lane select 0x1: no lane outputs, every access is a full word.
// - Low address on shared lines before data; upper address on lines 16 upward.
// - In configs 0x0 and 0x3 every access pulses the address latch enable while shared lines carry address.
// - Reads use the read strobe, writes the write strobe, on fixed lines.
// - Zero to two chip selects, each enabling one external peripheral.
// - With lane selects on, two outputs mark lower, upper or both bytes.
// - Chip select config: 0 latch only, 1 one select, 2 two, 3 latch plus two.
// - Config 0x3: line 30 latch, 26 select zero, 27 select one, address to 25.
// - Configs 0x1/0x2: line 30 select zero; 0x2 puts select one on line 27.
// - Byte lane select 0x0 drives the lane selects beside the muxed bus.
package whb_pkg;

  // ****************************************************************
  // Configuration encodings
  // ****************************************************************
  localparam logic [3:0] PORT_MODE_WIDE  = 4'h3;
  localparam logic [1:0] WIDE_MODE_MUXED = 2'h0;
  localparam logic [1:0] LANE_SEL_ON     = 2'h0;
  localparam logic [1:0] LANE_SEL_OFF    = 2'h1;
  localparam logic [1:0] CHIP_SELECT_CONFIG_ALE       = 2'h0;
  localparam logic [1:0] CHIP_SELECT_CONFIG_ONE_CS    = 2'h1;
  localparam logic [1:0] CHIP_SELECT_CONFIG_TWO_CS    = 2'h2;
  localparam logic [1:0] CHIP_SELECT_CONFIG_ALE_TWO   = 2'h3;

  // ****************************************************************
  // Widths and port line positions
  // ****************************************************************
  localparam int ADDR_W      = 28;
  localparam int DATA_W      = 16;
  localparam int LINES       = 32;
  localparam int LINE_UPPER  = 16;
  localparam int LINE_UP_END = 25;
  localparam int LINE_26     = 26;
  localparam int LINE_27     = 27;
  localparam int LINE_RD     = 28;
  localparam int LINE_WR     = 29;
  localparam int LINE_30     = 30;
  localparam int SEL_BIT_TWO = 27;
  localparam int SEL_BIT_ALE = 26;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ   = 50;
  localparam int ALE_NS    = 40;
  localparam int HOLD_NS   = 20;
  localparam int STROBE_NS = 80;
  localparam int RECOV_NS  = 20;
  localparam logic [3:0] ALE_CYC    = 4'((ALE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] HOLD_CYC   = 4'((HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] RECOV_CYC  = 4'((RECOV_NS * CLK_MHZ + 999) / 1000);

  // Access sequencer, Gray coded from idle to recovery; the return to idle flips two bits
  typedef enum logic [2:0] {
    WHB_IDLE   = 3'h0,
    WHB_ADDR   = 3'h1,
    WHB_HOLD   = 3'h3,
    WHB_STROBE = 3'h2,
    WHB_RECOV  = 3'h6
  } whb_state_e;

endpackage

//--- core/whb_port.sv
`timescale 1ns/1ps
`default_nettype none
module whb_port #(
  parameter int ADDR_W = whb_pkg::ADDR_W,
  parameter int DATA_W = whb_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Configuration
  input  wire logic [3:0]        port_mode,
  input  wire logic [1:0]        wide_mode,
  input  wire logic [1:0]        byte_lane_select,
  input  wire logic [1:0]        chip_select_config,
  output logic                   cfg_ok,
  // Access request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [1:0]        req_be,
  // Access response
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  // Port lines
  input  wire logic [DATA_W-1:0] line_in,
  output logic [31:0]            line_out,
  output logic [31:0]            line_oe,
  output logic [1:0]             byte_lane_n,
  output logic                   byte_lane_oe
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Active-high select vector for one access
  function automatic logic [1:0] cs_decode(input logic [1:0] cfg,
                                           input logic [ADDR_W-1:0] a);
    logic [1:0] r;
    r = 2'h0;
    case (cfg)
      whb_pkg::CHIP_SELECT_CONFIG_ONE_CS:  r = 2'h1;
      whb_pkg::CHIP_SELECT_CONFIG_TWO_CS:  r = a[whb_pkg::SEL_BIT_TWO] ? 2'h2 : 2'h1;
      whb_pkg::CHIP_SELECT_CONFIG_ALE_TWO: r = a[whb_pkg::SEL_BIT_ALE] ? 2'h2 : 2'h1;
      default:                r = 2'h0;
    endcase
    return r;
  endfunction

  function automatic logic ale_mode(input logic [1:0] cfg);
    return (cfg == whb_pkg::CHIP_SELECT_CONFIG_ALE) || (cfg == whb_pkg::CHIP_SELECT_CONFIG_ALE_TWO);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  whb_pkg::whb_state_e state_q, state_d;
  logic [3:0]          cnt_q, cnt_d;
  logic [ADDR_W-1:0]   addr_q, addr_d;
  logic [DATA_W-1:0]   wdata_q, wdata_d;
  logic [DATA_W-1:0]   rdata_q, rdata_d;
  logic [1:0]          be_q, be_d;
  logic                write_q, write_d;
  logic [1:0]          chip_select_config_q, chip_select_config_d;
  logic [1:0]          lsel_q, lsel_d;
  logic [1:0]          cs_q, cs_d;
  logic                rsp_q, rsp_d;
  logic [31:0]         out_q, out_d;
  logic [31:0]         oe_q, oe_d;
  logic [1:0]          lane_q, lane_d;
  logic                lane_oe_q, lane_oe_d;
  logic                accept;
  logic                ale_d;
  logic [1:0]          pin_cfg;

  assign cfg_ok = (port_mode == whb_pkg::PORT_MODE_WIDE) &&
                  (wide_mode == whb_pkg::WIDE_MODE_MUXED);
  assign req_ready = (state_q == whb_pkg::WHB_IDLE) && cfg_ok;
  assign accept    = req_valid && req_ready;
  assign rsp_valid    = rsp_q;
  assign rsp_rdata    = rdata_q;
  assign line_out     = out_q;
  assign line_oe      = oe_q;
  assign byte_lane_n  = lane_q;
  assign byte_lane_oe = lane_oe_q;

  // ****************************************************************
  // Sequencer and pin image
  // ****************************************************************
  // Pins are built from the next state so that they leave flip-flops
  // in step with state_q; this costs no cycle and avoids glitches.
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    addr_d    = addr_q;
    wdata_d   = wdata_q;
    rdata_d   = rdata_q;
    be_d      = be_q;
    write_d   = write_q;
    chip_select_config_d   = chip_select_config_q;
    lsel_d    = lsel_q;
    cs_d      = cs_q;
    rsp_d     = 1'b0;
    case (state_q)
      whb_pkg::WHB_IDLE: begin
        if (accept) begin
          state_d = whb_pkg::WHB_ADDR;
          cnt_d   = whb_pkg::ALE_CYC - 4'h1;
          addr_d  = req_addr;
          wdata_d = req_wdata;
          write_d = req_write;
          chip_select_config_d = chip_select_config;
          lsel_d  = byte_lane_select;
          be_d    = (byte_lane_select == whb_pkg::LANE_SEL_OFF) ? 2'h3 : req_be;
          cs_d    = cs_decode(chip_select_config, req_addr);
        end
      end
      whb_pkg::WHB_ADDR: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h0) begin
          state_d = whb_pkg::WHB_HOLD;
          cnt_d   = whb_pkg::HOLD_CYC - 4'h1;
        end
      end
      whb_pkg::WHB_HOLD: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h0) begin
          state_d = whb_pkg::WHB_STROBE;
          cnt_d   = whb_pkg::STROBE_CYC - 4'h1;
        end
      end
      whb_pkg::WHB_STROBE: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h0) begin
          state_d = whb_pkg::WHB_RECOV;
          cnt_d   = whb_pkg::RECOV_CYC - 4'h1;
          if (!write_q) begin
            rdata_d = line_in;
          end
        end
      end
      whb_pkg::WHB_RECOV: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h0) begin
          state_d = whb_pkg::WHB_IDLE;
          cnt_d   = 4'h0;
          rsp_d   = 1'b1;
          cs_d    = 2'h0;
        end
      end
      default: begin
        state_d = whb_pkg::WHB_IDLE;
        cnt_d   = 4'h0;
        cs_d    = 2'h0;
      end
    endcase

    // Default pin image: strobes and selects inactive, bus released
    out_d = 32'h0;
    oe_d  = 32'h0;
    // An idle port shows the live select layout, so a reconfigured port
    // never leaves a stale select asserted between accesses
    pin_cfg = (state_d == whb_pkg::WHB_IDLE) ? chip_select_config : chip_select_config_d;
    ale_d = (state_d == whb_pkg::WHB_ADDR) && ale_mode(pin_cfg);
    if (cfg_ok || (state_d != whb_pkg::WHB_IDLE)) begin
      // Shared lines: address first, write data only once address phase ends
      if ((state_d == whb_pkg::WHB_ADDR) || (state_d == whb_pkg::WHB_HOLD)) begin
        out_d[DATA_W-1:0] = addr_d[DATA_W-1:0];
        oe_d[DATA_W-1:0]  = {DATA_W{1'b1}};
      end else if (state_d != whb_pkg::WHB_IDLE && write_d) begin
        // Latch outside keeps the address from here on
        out_d[DATA_W-1:0] = wdata_d;
        oe_d[DATA_W-1:0]  = {DATA_W{1'b1}};
      end
      out_d[whb_pkg::LINE_UP_END:whb_pkg::LINE_UPPER] =
        addr_d[whb_pkg::LINE_UP_END:whb_pkg::LINE_UPPER];
      oe_d[whb_pkg::LINE_UP_END:whb_pkg::LINE_UPPER] = 10'h3FF;
      // Lines 26 and 27 carry address or selects per config
      out_d[whb_pkg::LINE_26] = (pin_cfg == whb_pkg::CHIP_SELECT_CONFIG_ALE_TWO) ?
                                ~cs_d[0] : addr_d[whb_pkg::LINE_26];
      out_d[whb_pkg::LINE_27] = (pin_cfg >= whb_pkg::CHIP_SELECT_CONFIG_TWO_CS) ?
                                ~cs_d[1] : addr_d[whb_pkg::LINE_27];
      oe_d[whb_pkg::LINE_27:whb_pkg::LINE_26] = 2'h3;
      // Fixed strobe lines, active low
      out_d[whb_pkg::LINE_RD] = !((state_d == whb_pkg::WHB_STROBE) && !write_d);
      out_d[whb_pkg::LINE_WR] = !((state_d == whb_pkg::WHB_STROBE) && write_d);
      oe_d[whb_pkg::LINE_WR:whb_pkg::LINE_RD] = 2'h3;
      // Line 30: latch enable (high) or select zero (low)
      out_d[whb_pkg::LINE_30] = ale_mode(pin_cfg) ? ale_d : ~cs_d[0];
      oe_d[whb_pkg::LINE_30]  = 1'b1;
    end
    // Lane selects, low-active, valid over the whole access
    lane_d    = 2'h3;
    lane_oe_d = cfg_ok && (byte_lane_select == whb_pkg::LANE_SEL_ON);
    if (state_d != whb_pkg::WHB_IDLE) begin
      lane_oe_d = (lsel_d == whb_pkg::LANE_SEL_ON);
      lane_d    = ~be_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q   <= whb_pkg::WHB_IDLE;
      cnt_q     <= 4'h0;
      addr_q    <= '0;
      wdata_q   <= '0;
      rdata_q   <= '0;
      be_q      <= 2'h0;
      write_q   <= 1'b0;
      chip_select_config_q   <= 2'h0;
      lsel_q    <= 2'h0;
      cs_q      <= 2'h0;
      rsp_q     <= 1'b0;
      out_q     <= 32'h0;
      oe_q      <= 32'h0;
      lane_q    <= 2'h3;
      lane_oe_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      addr_q    <= addr_d;
      wdata_q   <= wdata_d;
      rdata_q   <= rdata_d;
      be_q      <= be_d;
      write_q   <= write_d;
      chip_select_config_q   <= chip_select_config_d;
      lsel_q    <= lsel_d;
      cs_q      <= cs_d;
      rsp_q     <= rsp_d;
      out_q     <= out_d;
      oe_q      <= oe_d;
      lane_q    <= lane_d;
      lane_oe_q <= lane_oe_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_REFUSE_BAD_CFG: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!cfg_ok && state_q == whb_pkg::WHB_IDLE) |=> (state_q == whb_pkg::WHB_IDLE))
    else $error("request taken with wrong mode");

  AST_LANES_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q != whb_pkg::WHB_IDLE && lsel_q == whb_pkg::LANE_SEL_OFF) |-> !lane_oe_q)
    else $error("lane selects driven while disabled");

  AST_ADDR_ON_SHARED: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == whb_pkg::WHB_ADDR) |->
      (out_q[15:0] == addr_q[15:0]) && (oe_q[15:0] == 16'hFFFF))
    else $error("shared lines not carrying address");

  AST_ALE_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (accept && ale_mode(chip_select_config)) |=>
      out_q[30] [*2] ##1 !out_q[30])
    else $error("latch enable pulse wrong width");

  AST_STROBES_EXCL: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(!out_q[28] && !out_q[29] && oe_q[28]))
    else $error("read and write strobes together");

  AST_ONE_SELECT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q != whb_pkg::WHB_IDLE && chip_select_config_q != whb_pkg::CHIP_SELECT_CONFIG_ALE) |->
      ($countones(cs_q) == 1) && $stable(cs_q) || (state_q == whb_pkg::WHB_ADDR))
    else $error("select not single or not stable");

  AST_STROBE_AFTER_ALE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!out_q[28] || !out_q[29]) |-> !(ale_mode(chip_select_config_q) && out_q[30]))
    else $error("strobe overlaps latch enable");

  AST_WDATA_PHASE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == whb_pkg::WHB_STROBE && write_q) |-> (out_q[15:0] == wdata_q))
    else $error("write data missing in strobe phase");

  AST_CFG3_LINES: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q != whb_pkg::WHB_IDLE && chip_select_config_q == whb_pkg::CHIP_SELECT_CONFIG_ALE_TWO) |->
      (out_q[26] == !cs_q[0]) && (out_q[27] == !cs_q[1]))
    else $error("select lines wrong in latch-plus-two config");

  AST_ACCESS_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    accept |-> ##9 rsp_valid ##1 !rsp_valid)
    else $error("access length wrong");

  AST_CFG2_LINES: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q != whb_pkg::WHB_IDLE && chip_select_config_q == whb_pkg::CHIP_SELECT_CONFIG_TWO_CS) |->
      (out_q[whb_pkg::LINE_27] == !addr_q[whb_pkg::SEL_BIT_TWO]) && (out_q[whb_pkg::LINE_30] == addr_q[whb_pkg::SEL_BIT_TWO]))
    else $error("select lines wrong in two-select config");

  AST_ALE_ONLY_LINES: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q != whb_pkg::WHB_IDLE && chip_select_config_q == whb_pkg::CHIP_SELECT_CONFIG_ALE) |->
      (cs_q == 2'h0) && (out_q[whb_pkg::LINE_27:whb_pkg::LINE_26] == addr_q[whb_pkg::LINE_27:whb_pkg::LINE_26]))
    else $error("select driven in latch-only config");

  AST_LANE_IMAGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q != whb_pkg::WHB_IDLE && lsel_q == whb_pkg::LANE_SEL_ON) |->
      lane_oe_q && (lane_q == ~be_q))
    else $error("lane selects do not match access bytes");

  AST_READ_RELEASE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == whb_pkg::WHB_STROBE && !write_q) |->
      (oe_q[DATA_W-1:0] == '0) && !out_q[whb_pkg::LINE_RD])
    else $error("shared lines driven during read strobe");

endmodule // whb_port
`default_nettype wire
